// [design/frame_fifo_pkg.sv]
// constants shared by the sensor frame fifo control and its byte store
package frame_fifo_pkg;
  // ----------------------------------------
  // storage geometry
  // ----------------------------------------
  localparam int ADDR_W = 10;
  localparam int PTR_W = 11;
  localparam int DEPTH = 1024;
  localparam int SLOTS = 19;
  localparam int MAX_FRAME = 15;
  localparam logic [10:0] FULL_THR = 11'(DEPTH - 2 * MAX_FRAME);
  localparam logic [10:0] ROOM_MIN = 11'(SLOTS);
  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int ACC_BYTES = 6;
  localparam int AUX_MAX = 8;
  localparam int SLOT_CFG_H = 0;
  localparam int SLOT_CFG_P = 1;
  localparam int SLOT_DROP_H = 2;
  localparam int SLOT_DROP_P = 3;
  localparam int SLOT_DATA_H = 4;
  localparam int SLOT_AUX0 = 5;
  localparam int SLOT_ACC0 = 13;
  localparam logic [7:0] HDR_DATA = 8'h80;
  localparam logic [7:0] HDR_CFG = 8'h48;
  localparam logic [7:0] HDR_DROP = 8'h50;
  localparam int HDR_DATA_BIT = 7;
  localparam int HDR_CTRL_BIT = 6;
  localparam int HDR_AUX_BIT = 4;
  localparam int HDR_ACC_BIT = 2;
  localparam int DROP_AUX_BIT = 2;
  localparam int DROP_ACC_BIT = 0;
  localparam logic [7:0] INVALID_BYTE = 8'h80;
  localparam logic [15:0] OVERREAD_WORD = 16'h8000;
  localparam logic [7:0] CMD_FLUSH = 8'hB0;
  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_WTM_LOW = 8'h04;
  localparam logic [7:0] OFS_WTM_HIGH = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  localparam int CFG_W = 9;
  localparam int CFG_HDR = 0;
  localparam int CFG_ACC_EN = 1;
  localparam int CFG_AUX_EN = 2;
  localparam int CFG_AUX_SZ = 3;
  localparam int CFG_TAG1 = 5;
  localparam int CFG_TAG2 = 6;
  localparam int CFG_IN1 = 7;
  localparam int CFG_IN2 = 8;
  localparam logic [8:0] CFG_RESET = 9'h003;
  localparam int WTM_HIGH_W = 3;
  localparam int STAT_FULL = 0;
  localparam int STAT_WTM = 1;
  localparam int STAT_LVL = 16;
endpackage : frame_fifo_pkg

// [design/fifo_byte_ram.sv]
// byte store of the frame fifo, registered read port
`timescale 1ns/1ps
module fifo_byte_ram (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [frame_fifo_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [frame_fifo_pkg::ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [frame_fifo_pkg::DEPTH];

  // no reset: contents are only read below the committed write pointer
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule : fifo_byte_ram

// [design/sensor_frame_fifo_control.sv]
// frame fifo control of the acceleration sensor, apb register slave
//
// How it works
// - drop frame payload is one byte: bit 2 aux lost, bit 0 acc lost.
// - drop frame follows config frame at the tick, only if no sensor valid.
// - if another sensor is valid, data frame omits lost sensor, presence bit clear.
// - drop frames only in transitions, never before a sensor's first valid sample.
// - partly read frame is delivered whole again after an access to another register.
// - overflow between partial reads never discards the partly read frame; a tick without room is dropped.
// - overreads return 0x8000 headerless, 0x80 invalid byte in header mode.
// - samples share one output-rate grid; faster sensors join slower ones.
// - in transitions frames may lack higher-rate samples that have no data.
// - header external tag follows both interrupt pins when all enables set.
// - full interrupt when fill level exceeds capacity minus two frames.
// - watermark interrupt when fill level reaches programmed watermark.
// - both interrupts held off while a data register read burst runs.
// - latched interrupt clears on status read with level below threshold.
// - writing 0xB0 to the command register flushes the fifo.
// - sensor enable or disable in headerless mode flushes the fifo.
// - switching header and headerless mode flushes the fifo.
// - change of aux data size flushes the fifo.
// - in header mode, config change puts a config frame before the first new frame.
`timescale 1ns/1ps
module sensor_frame_fifo_control (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ODR_TICK,
  input wire logic ACC_VALID,
  input wire logic [47:0] ACC_DATA,
  input wire logic AUX_VALID,
  input wire logic [63:0] AUX_DATA,
  input wire logic [7:0] CONF_CHANGE,
  input wire logic INTERRUPT_PIN_ONE,
  input wire logic INTERRUPT_PIN_TWO,
  output logic FIFO_FULL_INT,
  output logic FIFO_WTM_INT
);
  typedef enum logic {ST_IDLE = 1'b0, ST_WRITE = 1'b1} state_t;

  function automatic logic [3:0] aux_len(input logic [1:0] sz);
    aux_len = 4'(1 << sz);
  endfunction : aux_len

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic pready_q;
  logic [frame_fifo_pkg::CFG_W-1:0] cfg_q;
  logic [7:0] wtm_lo_q;
  logic [frame_fifo_pkg::WTM_HIGH_W-1:0] wtm_hi_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  wire acc_w = PSEL && PENABLE;
  wire take_w = acc_w && !pready_q;
  wire done_w = acc_w && pready_q;
  wire a_cfg = PADDR == frame_fifo_pkg::OFS_CONFIG;
  wire a_wlo = PADDR == frame_fifo_pkg::OFS_WTM_LOW;
  wire a_whi = PADDR == frame_fifo_pkg::OFS_WTM_HIGH;
  wire a_cmd = PADDR == frame_fifo_pkg::OFS_CMD;
  wire a_st = PADDR == frame_fifo_pkg::OFS_STATUS;
  wire a_dat = PADDR == frame_fifo_pkg::OFS_DATA;
  wire mapped_w = a_cfg || a_wlo || a_whi || a_cmd || a_st || a_dat;
  wire wr_done = done_w && PWRITE;
  wire cfg_wr = wr_done && a_cfg;
  wire dat_rd = done_w && !PWRITE && a_dat;
  wire st_rd = done_w && !PWRITE && a_st;
  wire other_done = done_w && !a_dat;
  wire hdr_m = cfg_q[frame_fifo_pkg::CFG_HDR];
  wire acc_en = cfg_q[frame_fifo_pkg::CFG_ACC_EN];
  wire aux_en = cfg_q[frame_fifo_pkg::CFG_AUX_EN];
  wire [1:0] aux_sz = cfg_q[frame_fifo_pkg::CFG_AUX_SZ +: 2];
  wire [frame_fifo_pkg::CFG_W-1:0] new_cfg = PWDATA[frame_fifo_pkg::CFG_W-1:0];
  wire [10:0] wtm_w = {wtm_hi_q, wtm_lo_q};

  // ----------------------------------------
  // automatic and commanded flush
  // ----------------------------------------
  // flush command
  wire cmd_flush = wr_done && a_cmd && PWDATA[7:0] == frame_fifo_pkg::CMD_FLUSH;
  wire mode_flip = cfg_wr && new_cfg[frame_fifo_pkg::CFG_HDR] != hdr_m;
  wire en_flip = cfg_wr && !hdr_m && new_cfg[frame_fifo_pkg::CFG_AUX_EN:frame_fifo_pkg::CFG_ACC_EN]
    != cfg_q[frame_fifo_pkg::CFG_AUX_EN:frame_fifo_pkg::CFG_ACC_EN];
  wire sz_flip = cfg_wr && new_cfg[frame_fifo_pkg::CFG_AUX_SZ +: 2] != aux_sz;
  wire flush_w = cmd_flush || mode_flip || en_flip || sz_flip;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] pin_meta_q;
  logic [1:0] pin_q;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_meta_q <= 2'h0;
      pin_q <= 2'h0;
    end else if (CE) begin
      pin_meta_q <= {INTERRUPT_PIN_TWO, INTERRUPT_PIN_ONE};
      pin_q <= pin_meta_q;
    end
  end
  wire tag_on = cfg_q[frame_fifo_pkg::CFG_TAG1] && cfg_q[frame_fifo_pkg::CFG_TAG2]
    && cfg_q[frame_fifo_pkg::CFG_IN1] && cfg_q[frame_fifo_pkg::CFG_IN2];
  wire [1:0] header_external_tag = tag_on ? pin_q : 2'h0;

  // ----------------------------------------
  // frame composition at the output-rate tick
  // ----------------------------------------
  logic trans_q;
  logic seen_acc_q;
  logic seen_aux_q;
  logic [7:0] cfg_pend_q;
  wire acc_ok = acc_en && ACC_VALID;
  wire aux_ok = aux_en && AUX_VALID;
  // loss counts only after first valid sample, in transitions
  wire lost_acc = trans_q && acc_en && seen_acc_q && !ACC_VALID;
  wire lost_aux = trans_q && aux_en && seen_aux_q && !AUX_VALID;
  // drop frame only when nothing valid
  wire drop_now = hdr_m && (lost_acc || lost_aux) && !acc_ok && !aux_ok;
  // headerless frames need every enabled sensor on the common tick
  wire full_set = (acc_ok || !acc_en) && (aux_ok || !aux_en) && (acc_en || aux_en);
  // header mode keeps whatever is valid in transitions
  wire data_now = hdr_m ? (acc_ok || aux_ok) : full_set;
  // config frame ahead of new frames
  wire cfg_now = hdr_m && cfg_pend_q != 8'h00;
  logic [7:0] slot_b [frame_fifo_pkg::SLOTS];
  logic [frame_fifo_pkg::SLOTS-1:0] slot_m;
  // presence bits follow valid samples only
  assign slot_b[frame_fifo_pkg::SLOT_DATA_H] = frame_fifo_pkg::HDR_DATA
    | 8'(aux_ok) << frame_fifo_pkg::HDR_AUX_BIT | 8'(acc_ok) << frame_fifo_pkg::HDR_ACC_BIT
    | {6'h00, header_external_tag};
  assign slot_b[frame_fifo_pkg::SLOT_CFG_H] = frame_fifo_pkg::HDR_CFG;
  assign slot_b[frame_fifo_pkg::SLOT_CFG_P] = cfg_pend_q;
  assign slot_b[frame_fifo_pkg::SLOT_DROP_H] = frame_fifo_pkg::HDR_DROP;
  assign slot_b[frame_fifo_pkg::SLOT_DROP_P] = 8'(lost_aux) << frame_fifo_pkg::DROP_AUX_BIT
    | 8'(lost_acc) << frame_fifo_pkg::DROP_ACC_BIT;
  assign slot_m[frame_fifo_pkg::SLOT_CFG_H] = cfg_now;
  assign slot_m[frame_fifo_pkg::SLOT_CFG_P] = cfg_now;
  assign slot_m[frame_fifo_pkg::SLOT_DROP_H] = drop_now;
  assign slot_m[frame_fifo_pkg::SLOT_DROP_P] = drop_now;
  assign slot_m[frame_fifo_pkg::SLOT_DATA_H] = hdr_m && data_now;
  for (genvar i = 0; i < frame_fifo_pkg::AUX_MAX; i++) begin : g_aux
    assign slot_b[frame_fifo_pkg::SLOT_AUX0 + i] = AUX_DATA[8*i +: 8];
    assign slot_m[frame_fifo_pkg::SLOT_AUX0 + i] = data_now && aux_ok && 4'(i) < aux_len(aux_sz);
  end
  for (genvar i = 0; i < frame_fifo_pkg::ACC_BYTES; i++) begin : g_acc
    assign slot_b[frame_fifo_pkg::SLOT_ACC0 + i] = ACC_DATA[8*i +: 8];
    assign slot_m[frame_fifo_pkg::SLOT_ACC0 + i] = data_now && acc_ok;
  end

  // ----------------------------------------
  // writer
  // ----------------------------------------
  state_t state_q;
  logic [7:0] fr_q [frame_fifo_pkg::SLOTS];
  logic [frame_fifo_pkg::SLOTS-1:0] fm_q;
  logic [4:0] idx_q;
  logic [frame_fifo_pkg::PTR_W-1:0] wr_ptr_q;
  logic [frame_fifo_pkg::PTR_W-1:0] wr_com_q;
  logic [frame_fifo_pkg::PTR_W-1:0] rd_ptr_q;
  logic [frame_fifo_pkg::PTR_W-1:0] rd_start_q;
  wire [10:0] level_w = wr_com_q - rd_start_q;
  // stop on full: a tick with too little room is dropped whole, so a partly
  // read frame is never overwritten and always repeatable
  // discard never needed
  wire room_ok = 11'(frame_fifo_pkg::DEPTH) - level_w >= frame_fifo_pkg::ROOM_MIN;
  wire start_w = ODR_TICK && state_q == ST_IDLE && room_ok && slot_m != '0;
  wire wr_en = state_q == ST_WRITE && fm_q[idx_q];
  wire last_w = idx_q == 5'(frame_fifo_pkg::SLOTS - 1);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
      fm_q <= '0;
      idx_q <= 5'h00;
      wr_ptr_q <= '0;
      wr_com_q <= '0;
    end else if (CE) begin
      if (flush_w) begin
        state_q <= ST_IDLE;
        wr_ptr_q <= '0;
        wr_com_q <= '0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            idx_q <= 5'h00;
            if (start_w) begin
              fm_q <= slot_m;
              state_q <= ST_WRITE;
            end
          end
          ST_WRITE: begin
            idx_q <= idx_q + 5'h01;
            if (wr_en) begin
              wr_ptr_q <= wr_ptr_q + 11'h001;
            end
            if (last_w) begin
              wr_com_q <= wr_en ? wr_ptr_q + 11'h001 : wr_ptr_q;
              state_q <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (CE && start_w) begin
      fr_q <= slot_b;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      trans_q <= 1'b0;
      seen_acc_q <= 1'b0;
      seen_aux_q <= 1'b0;
      cfg_pend_q <= 8'h00;
    end else if (CE) begin
      seen_acc_q <= acc_en && (seen_acc_q || ACC_VALID);
      seen_aux_q <= aux_en && (seen_aux_q || AUX_VALID);
      if (CONF_CHANGE != 8'h00) begin
        trans_q <= 1'b1;
      end else if (ODR_TICK && full_set) begin
        trans_q <= 1'b0;
      end
      if (start_w) begin
        cfg_pend_q <= CONF_CHANGE;
      end else begin
        cfg_pend_q <= cfg_pend_q | CONF_CHANGE;
      end
    end
  end

  logic [7:0] ram_q;
  fifo_byte_ram u_ram (
    .clk(CLK),
    .ce(CE),
    .wr_en(wr_en && !flush_w),
    .wr_addr(wr_ptr_q[frame_fifo_pkg::ADDR_W-1:0]),
    .wr_data(fr_q[idx_q]),
    .rd_addr(rd_ptr_q[frame_fifo_pkg::ADDR_W-1:0]),
    .rd_data(ram_q)
  );

  // ----------------------------------------
  // reader
  // ----------------------------------------
  logic [3:0] left_q;
  logic burst_q;
  logic ovr_tog_q;
  wire avail_w = rd_ptr_q != wr_com_q;
  wire [3:0] n_aux = aux_len(aux_sz);
  wire [3:0] hl_len = (acc_en ? 4'(frame_fifo_pkg::ACC_BYTES) : 4'h0) + (aux_en ? n_aux : 4'h0);
  wire [3:0] hd_len = ram_q[frame_fifo_pkg::HDR_DATA_BIT]
    ? 4'h1 + (ram_q[frame_fifo_pkg::HDR_AUX_BIT] ? n_aux : 4'h0)
      + (ram_q[frame_fifo_pkg::HDR_ACC_BIT] ? 4'(frame_fifo_pkg::ACC_BYTES) : 4'h0)
    : (ram_q[frame_fifo_pkg::HDR_CTRL_BIT] ? 4'h2 : 4'h1);
  wire [3:0] len_now = left_q != 4'h0 ? left_q : (hdr_m ? hd_len : hl_len);
  wire [7:0] ovr_b = hdr_m ? frame_fifo_pkg::INVALID_BYTE
    : (ovr_tog_q ? frame_fifo_pkg::OVERREAD_WORD[15:8] : frame_fifo_pkg::OVERREAD_WORD[7:0]);
  wire [7:0] dat_b = avail_w ? ram_q : ovr_b;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_ptr_q <= '0;
      rd_start_q <= '0;
      left_q <= 4'h0;
      burst_q <= 1'b0;
      ovr_tog_q <= 1'b0;
    end else if (CE) begin
      if (flush_w) begin
        rd_ptr_q <= '0;
        rd_start_q <= '0;
        left_q <= 4'h0;
        burst_q <= 1'b0;
      end else if (dat_rd) begin
        burst_q <= 1'b1;
        if (avail_w) begin
          // advance and commit on frame end
          rd_ptr_q <= rd_ptr_q + 11'h001;
          left_q <= len_now - 4'h1;
          if (len_now == 4'h1) begin
            rd_start_q <= rd_ptr_q + 11'h001;
          end
        end else begin
          ovr_tog_q <= !ovr_tog_q;
        end
      end else if (other_done) begin
        rd_ptr_q <= rd_start_q;
        left_q <= 4'h0;
        burst_q <= 1'b0;
        ovr_tog_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // fifo interrupts
  // ----------------------------------------
  // full threshold
  wire full_c = level_w > frame_fifo_pkg::FULL_THR;
  wire wtm_c = level_w >= wtm_w;
  logic full_q;
  logic wtm_q;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      full_q <= 1'b0;
      wtm_q <= 1'b0;
    end else if (CE) begin
      // held off in bursts; set wins over status clear
      full_q <= (full_c && !burst_q) || (full_q && !(st_rd && !full_c));
      wtm_q <= (wtm_c && !burst_q) || (wtm_q && !(st_rd && !wtm_c));
    end
  end
  assign FIFO_FULL_INT = full_q;
  assign FIFO_WTM_INT = wtm_q;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  wire [31:0] st_w = 32'(level_w) << frame_fifo_pkg::STAT_LVL
    | 32'(full_q) << frame_fifo_pkg::STAT_FULL | 32'(wtm_q) << frame_fifo_pkg::STAT_WTM;
  wire [31:0] rd_mux = a_cfg ? 32'(cfg_q) : a_wlo ? 32'(wtm_lo_q) : a_whi ? 32'(wtm_hi_q)
    : a_st ? st_w : a_dat ? 32'(dat_b) : 32'h0000_0000;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      cfg_q <= frame_fifo_pkg::CFG_RESET;
      wtm_lo_q <= 8'h00;
      wtm_hi_q <= '0;
    end else if (CE) begin
      pready_q <= take_w;
      if (take_w) begin
        prdata_q <= PWRITE ? 32'h0000_0000 : rd_mux;
        pslverr_q <= !mapped_w;
      end
      if (cfg_wr) begin
        cfg_q <= new_cfg;
      end
      if (wr_done && a_wlo) begin
        wtm_lo_q <= PWDATA[7:0];
      end
      if (wr_done && a_whi) begin
        wtm_hi_q <= PWDATA[frame_fifo_pkg::WTM_HIGH_W-1:0];
      end
    end
  end
  assign PREADY = pready_q;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_full_set;
    @(posedge CLK) disable iff (!RESET_N) CE && full_c && !burst_q |=> FIFO_FULL_INT;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full interrupt not raised");
  property p_wtm_set;
    @(posedge CLK) disable iff (!RESET_N) CE && wtm_c && !burst_q |=> FIFO_WTM_INT;
  endproperty
  a_wtm_set: assert property (p_wtm_set) else $error("watermark interrupt not raised");
  property p_hold_off;
    @(posedge CLK) disable iff (!RESET_N) $rose(FIFO_WTM_INT) |-> !$past(burst_q);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("interrupt rose during burst");
  property p_clear;
    @(posedge CLK) disable iff (!RESET_N) $fell(FIFO_FULL_INT) |-> $past(st_rd);
  endproperty
  a_clear: assert property (p_clear) else $error("full cleared without status read");
  property p_flush;
    @(posedge CLK) disable iff (!RESET_N) CE && cmd_flush |=> level_w == 11'h000 && !avail_w;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left data");
  property p_mode;
    @(posedge CLK) disable iff (!RESET_N) CE && mode_flip |=> wr_ptr_q == '0 && state_q == ST_IDLE;
  endproperty
  a_mode: assert property (p_mode) else $error("mode switch did not reset");
  property p_overread;
    @(posedge CLK) disable iff (!RESET_N)
      CE && take_w && !PWRITE && a_dat && !avail_w && hdr_m |=> PRDATA == 32'h0000_0080 && PREADY;
  endproperty
  a_overread: assert property (p_overread) else $error("wrong overread byte");
  property p_rewind;
    @(posedge CLK) disable iff (!RESET_N)
      CE && other_done && !flush_w |=> rd_ptr_q == $past(rd_start_q) && left_q == 4'h0;
  endproperty
  a_rewind: assert property (p_rewind) else $error("partial frame not rewound");
endmodule : sensor_frame_fifo_control

// [tb/host_apb_model.sv]
// apb host model that reaches the frame fifo registers
`timescale 1ns/1ps
module host_apb_model (
  input wire logic CLK,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [7:0] PADDR,
  output logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  logic err_q;
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    err_q = 1'b0;
  end
  // ----------------------------------------
  // one transfer, held until pready
  // ----------------------------------------
  // interrupt lines are watched directly; pin mapping lies outside this block
  // waits as long as the slave needs; only the bench watchdog ends a hang
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err_q = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : xfer
endmodule : host_apb_model

// [tb/sensor_frame_fifo_control_test.sv]
// self-checking bench of the sensor frame fifo control
`timescale 1ns/1ps
module sensor_frame_fifo_control_test;
  logic CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic ODR_TICK, ACC_VALID, INTERRUPT_PIN_ONE, INTERRUPT_PIN_TWO;
  logic [47:0] ACC_DATA;
  logic [7:0] CONF_CHANGE;
  logic FIFO_FULL_INT, FIFO_WTM_INT;
  logic [7:0] exp_q[$];
  int error_cnt, checks, seed;
  sensor_frame_fifo_control dut (.CLK(CLK), .RESET_N(RESET_N), .CE(1'b1), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .ODR_TICK(ODR_TICK), .ACC_VALID(ACC_VALID),
    .ACC_DATA(ACC_DATA), .AUX_VALID(1'b0), .AUX_DATA(64'h0), .CONF_CHANGE(CONF_CHANGE),
    .INTERRUPT_PIN_ONE(INTERRUPT_PIN_ONE), .INTERRUPT_PIN_TWO(INTERRUPT_PIN_TWO),
    .FIFO_FULL_INT(FIFO_FULL_INT), .FIFO_WTM_INT(FIFO_WTM_INT));
  host_apb_model host (.CLK(CLK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask : wr
  task rdr(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, rd);
  endtask : rdr
  // one output-rate tick; the writer needs up to 19 cycles, 24 leaves margin
  task tick(input logic v, input logic hdr_en, input logic [7:0] hdr);
    logic [47:0] d;
    d = 48'({$random(seed), $random(seed)});
    @(posedge CLK);
    ODR_TICK <= 1'b1;
    ACC_VALID <= v;
    ACC_DATA <= d;
    if (hdr_en && v) exp_q.push_back(hdr);
    if (v) for (int i = 0; i < 6; i++) exp_q.push_back(d[8*i+:8]);
    @(posedge CLK);
    ODR_TICK <= 1'b0;
    ACC_VALID <= 1'b0;
    repeat (24) @(posedge CLK);
  endtask : tick
  task drain(input int n);
    for (int i = 0; i < n; i++) begin
      rdr(frame_fifo_pkg::OFS_DATA);
      chk("data", rd, {24'h0, exp_q.pop_front()});
    end
  endtask : drain
  task peek(input int n);
    for (int i = 0; i < n; i++) begin
      rdr(frame_fifo_pkg::OFS_DATA);
      chk("partial", rd, {24'h0, exp_q[i]});
    end
    rdr(frame_fifo_pkg::OFS_STATUS);
  endtask : peek
  task lvl(input int n);
    rdr(frame_fifo_pkg::OFS_STATUS);
    chk("level", {21'h0, rd[26:16]}, 32'(n));
  endtask : lvl
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h4A39;
    RESET_N = 1'b0;
    ODR_TICK = 1'b0;
    ACC_VALID = 1'b0;
    ACC_DATA = 48'h0;
    CONF_CHANGE = 8'h00;
    INTERRUPT_PIN_ONE = 1'b1;
    INTERRUPT_PIN_TWO = 1'b1;
    error_cnt = 0;
    checks = 0;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    rdr(frame_fifo_pkg::OFS_CONFIG);
    chk("config", rd, 32'(frame_fifo_pkg::CFG_RESET));
    rdr(8'h20);
    chk("slverr", 32'(host.err_q), 32'h1);
    // header frame, partial read then whole again, then overread
    tick(1'b1, 1'b1, 8'h84);
    lvl(7);
    peek(2);
    drain(7);
    rdr(frame_fifo_pkg::OFS_DATA);
    chk("overread", rd, 32'h80);
    // config change, lost sample, then data again
    @(posedge CLK);
    CONF_CHANGE <= 8'h01;
    @(posedge CLK);
    CONF_CHANGE <= 8'h00;
    exp_q = '{8'h48, 8'h01, 8'h50, 8'h01};
    tick(1'b0, 1'b1, 8'h00);
    tick(1'b1, 1'b1, 8'h84);
    drain(11);
    // pin tagging with both pins high
    wr(frame_fifo_pkg::OFS_CONFIG, 32'h1E3);
    tick(1'b1, 1'b1, 8'h87);
    drain(7);
    tick(1'b1, 1'b1, 8'h87);
    wr(frame_fifo_pkg::OFS_CONFIG, 32'h002);
    lvl(0);
    exp_q.delete();
    // headerless frames, partial read, overread pattern
    repeat (3) tick(1'b1, 1'b0, 8'h00);
    lvl(18);
    peek(3);
    drain(18);
    rdr(frame_fifo_pkg::OFS_DATA);
    chk("overread lo", rd, 32'h00);
    rdr(frame_fifo_pkg::OFS_DATA);
    chk("overread hi", rd, 32'h80);
    // watermark set and clear
    wr(frame_fifo_pkg::OFS_WTM_LOW, 32'd12);
    wr(frame_fifo_pkg::OFS_WTM_HIGH, 32'h0);
    rdr(frame_fifo_pkg::OFS_STATUS);
    repeat (2) @(posedge CLK);
    chk("wtm clear", 32'(FIFO_WTM_INT), 32'h0);
    tick(1'b1, 1'b0, 8'h00);
    chk("wtm below", 32'(FIFO_WTM_INT), 32'h0);
    tick(1'b1, 1'b0, 8'h00);
    chk("wtm reached", 32'(FIFO_WTM_INT), 32'h1);
    rdr(frame_fifo_pkg::OFS_STATUS);
    repeat (2) @(posedge CLK);
    chk("wtm kept", 32'(FIFO_WTM_INT), 32'h1);
    drain(6);
    rdr(frame_fifo_pkg::OFS_STATUS);
    repeat (2) @(posedge CLK);
    chk("wtm cleared", 32'(FIFO_WTM_INT), 32'h0);
    // flush command and enable change flush
    wr(frame_fifo_pkg::OFS_CMD, 32'(frame_fifo_pkg::CMD_FLUSH));
    lvl(0);
    tick(1'b1, 1'b0, 8'h00);
    wr(frame_fifo_pkg::OFS_CONFIG, 32'h000);
    lvl(0);
    wr(frame_fifo_pkg::OFS_CONFIG, 32'h002);
    exp_q.delete();
    // fill to the full threshold, held off during a read burst
    repeat (165) tick(1'b1, 1'b0, 8'h00);
    chk("full below", 32'(FIFO_FULL_INT), 32'h0);
    rdr(frame_fifo_pkg::OFS_DATA);
    tick(1'b1, 1'b0, 8'h00);
    chk("full held", 32'(FIFO_FULL_INT), 32'h0);
    rdr(frame_fifo_pkg::OFS_STATUS);
    repeat (2) @(posedge CLK);
    chk("full set", 32'(FIFO_FULL_INT), 32'h1);
    report_and_stop();
  end
  // the run needs some 5000 cycles; this limit leaves a wide margin
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule : sensor_frame_fifo_control_test
